// [design/decode_if.sv]
/*
 Decoded instruction fields passed from the decoder to the execute logic.
 Assumes the producer drives every field combinationally from one word.
*/
`timescale 1ns/1ps
interface decode_if;
    logic [5:0]  opcode;     // Primary opcode
    logic [4:0]  field_a;    // Bits 6-10: source or condition mask
    logic [4:0]  field_b;    // Bits 11-15: target or compare register
    logic [4:0]  field_c;    // Bits 16-20: third register
    logic [9:0]  ext_op;     // Bits 21-30: extended opcode
    logic        rec;        // Bit 31: record result
    logic [15:0] imm;        // Bits 16-31: immediate
    logic        is_trap;    // Immediate trap
    logic        is_xor;     // Register xor
    logic        is_xor_lo;  // Low immediate xor
    logic        is_xor_hi;  // High immediate xor

    modport producer (output opcode, field_a, field_b, field_c, ext_op, rec, imm,
                      output is_trap, is_xor, is_xor_lo, is_xor_hi);
    modport consumer (input opcode, field_a, field_b, field_c, ext_op, rec, imm,
                      input is_trap, is_xor, is_xor_lo, is_xor_hi);
endinterface

// [design/exec_pkg.sv]
/*
 Constants, types and helper functions shared by the trap and XOR execute slice.
 Assumes a 32-bit instruction word with bit 0 of the printed layout at bit 31 here.
*/
// Summary of operation
// - Opcode 3 compares register with sign-extended immediate
// - Condition bits: slt, sgt, eq, ult, ugt
// - Nonzero masked compare raises trap interrupt
// - Immediate trap leaves exception register, field 0
// - Opcode 31/316 writes xor of two registers
// - Record bit updates field 0 LT GT EQ SO
// - Register xor never touches exception register
// - Opcode 26 xors zero-extended low immediate
// - Opcode 27 xors immediate in upper half
// - Immediate xors leave exception register, field 0
// - Immediate fields: 6-10, 11-15, 16-31
package exec_pkg;

    // Primary and extended opcodes
    localparam logic [5:0] OP_TRAP_IMM = 6'h03;
    localparam logic [5:0] OP_EXTENDED = 6'h1F;
    localparam logic [5:0] OP_XOR_LOW  = 6'h1A;
    localparam logic [5:0] OP_XOR_HIGH = 6'h1B;
    localparam logic [9:0] XO_XOR      = 10'h13C;

    // Condition mask bit positions (field bit 0 is the MSB)
    localparam int COND_SLT = 4;
    localparam int COND_SGT = 3;
    localparam int COND_EQ  = 2;
    localparam int COND_ULT = 1;
    localparam int COND_UGT = 0;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] IRQ_EN_OFS    = 8'h08;
    localparam logic [7:0] IRQ_CLR_OFS   = 8'h0C;
    localparam logic [7:0] TRAP_ADDR_OFS = 8'h10;

    // Field positions and reset values
    localparam int          CTRL_ENABLE_BIT = 0;
    localparam int          ST_TRAP_BIT     = 0;
    localparam int          ST_UNHANDLED    = 1;
    localparam int          EVENT_W         = 2;
    localparam logic [31:0] CTRL_RST        = 32'h0000_0001;
    localparam logic [1:0]  IRQ_EN_RST      = 2'h0;

    // Execute state
    typedef enum logic [0:0] {
        ST_RUN  = 1'b0,
        ST_TRAP = 1'b1
    } exe_state_t;

    // Sign extension of the 16-bit immediate
    function automatic logic [31:0] sext16(input logic [15:0] imm);
        return {{16{imm[15]}}, imm};
    endfunction

    // Five compare outcomes of a against b, in mask order
    function automatic logic [4:0] cmp_hits(input logic [31:0] a, input logic [31:0] b);
        logic [4:0] h;
        h = 5'h00;
        h[COND_SLT] = $signed(a) < $signed(b);
        h[COND_SGT] = $signed(a) > $signed(b);
        h[COND_EQ]  = a == b;
        h[COND_ULT] = a < b;
        h[COND_UGT] = a > b;
        return h;
    endfunction

endpackage

// [design/instr_decoder.sv]
/*
 Instruction field decoder for the trap and XOR execute slice.
 Assumes the instruction word is stable while the issue strobe is high.
*/
`timescale 1ns/1ps
module instr_decoder
    import exec_pkg::*;
(
    input wire logic [31:0] instr, // Instruction word
    decode_if.producer      dec    // Decoded fields
);

    // Big-endian bit numbering: printed bit n sits at bit 31-n
    always_comb begin
        dec.opcode  = instr[31:26];
        dec.field_a = instr[25:21];
        dec.field_b = instr[20:16];
        dec.field_c = instr[15:11];
        dec.ext_op  = instr[10:1];
        dec.rec     = instr[0];
        dec.imm     = instr[15:0];
    end

    // Operation classes; anything else is reported as unhandled
    always_comb begin
        dec.is_trap   = instr[31:26] == OP_TRAP_IMM;
        dec.is_xor    = (instr[31:26] == OP_EXTENDED) && (instr[10:1] == XO_XOR);
        dec.is_xor_lo = instr[31:26] == OP_XOR_LOW;
        dec.is_xor_hi = instr[31:26] == OP_XOR_HIGH;
    end

endmodule

// [design/word_trap_and_xor_unit.sv]
/*
 Execute slice for the immediate word trap and the XOR family, with an
 APB register file for control, event status and interrupt.
 Assumes operands are read by the register stage in the issue cycle and
 that the exception unit acknowledges a trap with a one-cycle pulse.
*/
`timescale 1ns/1ps
module word_trap_and_xor_unit
    import exec_pkg::*;
(
    input  wire logic        pclk,        // Core clock, 20 MHz
    input  wire logic        presetn,     // Async reset, active low
    input  wire logic [7:0]  paddr,       // APB byte address
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB access phase
    input  wire logic        pwrite,      // APB write
    input  wire logic [31:0] pwdata,      // APB write data
    output logic      [31:0] prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr,     // APB error, unmapped
    output logic             irq,         // Level interrupt
    input  wire logic        issue_valid, // Instruction offered
    output logic             issue_ready, // Slice accepts
    input  wire logic [31:0] instr,       // Instruction word
    input  wire logic [31:0] instr_addr,  // Instruction address
    input  wire logic [31:0] src_value,   // Register at bits 6-10
    input  wire logic [31:0] cmp_value,   // Register at bits 11-15
    input  wire logic [31:0] rhs_value,   // Register at bits 16-20
    input  wire logic        so_in,       // Summary overflow now
    input  wire logic        trap_ack,    // Interrupt taken
    output logic             wb_valid,    // Writeback pulse
    output logic      [4:0]  wb_reg,      // Target register
    output logic      [31:0] wb_data,     // Result
    output logic             cr0_we,      // Field 0 update pulse
    output logic      [3:0]  cr0_value,   // LT GT EQ SO
    output logic             trap_req,    // Program interrupt request
    output logic      [31:0] trap_addr    // Trapping address
);

    // Decoded fields
    decode_if dec_bus ();

    // Field decoder instance
    instr_decoder u_dec (
        .instr (instr),
        .dec   (dec_bus)
    );

    // Control and status storage
    logic [31:0]        ctrl;         // Control register
    logic [EVENT_W-1:0] status;       // Sticky events
    logic [EVENT_W-1:0] irq_en;       // Interrupt enables
    logic [EVENT_W-1:0] event_set;    // Events this cycle
    logic [EVENT_W-1:0] clr_mask;     // Software clear this cycle
    exe_state_t         state;        // Run or trap pending

    // Execute datapath signals
    logic        take;         // Instruction accepted
    logic [31:0] imm_sext;     // Sign-extended immediate
    logic [4:0]  hits;         // Compare outcomes
    logic        trap_fire;    // Trap taken by this instruction
    logic        write_back;   // Result goes to register file
    logic [31:0] next_result;  // Result value
    logic        unhandled;    // Opcode not served here

    // APB phase decode
    logic setup;    // Setup cycle
    logic access;   // Completing access
    logic mapped;   // Address in map

    // Accept only while enabled and no trap pending
    assign take = issue_valid && issue_ready;

    // Compare operand and outcomes
    assign imm_sext = sext16(dec_bus.imm);
    assign hits     = cmp_hits(cmp_value, imm_sext);

    // Masked compare decides the trap
    assign trap_fire = take && dec_bus.is_trap &&
                       ((hits & dec_bus.field_a) != 5'h00);

    // Only the three XOR forms write a result
    assign write_back = take && (dec_bus.is_xor || dec_bus.is_xor_lo || dec_bus.is_xor_hi);

    // Unknown operation seen at issue
    assign unhandled = take && !(dec_bus.is_trap || dec_bus.is_xor ||
                                 dec_bus.is_xor_lo || dec_bus.is_xor_hi);

    // Result selection
    always_comb begin
        next_result = 32'h0000_0000;
        if (dec_bus.is_xor) begin
            next_result = src_value ^ rhs_value;
        end else if (dec_bus.is_xor_lo) begin
            next_result = src_value ^ {16'h0000, dec_bus.imm};
        end else if (dec_bus.is_xor_hi) begin
            next_result = src_value ^ {dec_bus.imm, 16'h0000};
        end
    end

    // Execute state: a trap stalls issue until the interrupt is taken
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_RUN;
        end else begin
            case (state)
                ST_RUN: begin
                    if (trap_fire) begin
                        state <= ST_TRAP;
                    end
                end
                ST_TRAP: begin
                    if (trap_ack) begin
                        state <= ST_RUN;
                    end
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // Ready drops the edge after a trap, so nothing later retires
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            issue_ready <= 1'b0;
        end else if (trap_fire) begin
            issue_ready <= 1'b0;
        end else if (state == ST_TRAP) begin
            issue_ready <= trap_ack && ctrl[CTRL_ENABLE_BIT];
        end else begin
            issue_ready <= ctrl[CTRL_ENABLE_BIT];
        end
    end

    // Trap request held until the exception unit acknowledges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_req  <= 1'b0;
            trap_addr <= 32'h0000_0000;
        end else if (trap_fire) begin
            trap_req  <= 1'b1;
            trap_addr <= instr_addr;
        end else if (trap_ack) begin
            trap_req  <= 1'b0;
        end
    end

    // Writeback; traps never write a register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wb_valid <= 1'b0;
            wb_reg   <= 5'h00;
            wb_data  <= 32'h0000_0000;
        end else begin
            wb_valid <= write_back;
            if (write_back) begin
                wb_reg  <= dec_bus.field_b;
                wb_data <= next_result;
            end
        end
    end

    // Field 0 update only for the register xor with record set.
    // No exception register output exists: none of these forms writes it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cr0_we    <= 1'b0;
            cr0_value <= 4'h0;
        end else begin
            cr0_we <= take && dec_bus.is_xor && dec_bus.rec;
            if (take && dec_bus.is_xor && dec_bus.rec) begin
                cr0_value <= {next_result[31],
                              !next_result[31] && (next_result != 32'h0000_0000),
                              next_result == 32'h0000_0000,
                              so_in};
            end
        end
    end

    // APB phases
    assign setup  = psel && !penable;
    assign access = psel && penable && pready;
    assign mapped = (paddr == CTRL_OFS) || (paddr == STATUS_OFS) || (paddr == IRQ_EN_OFS) ||
                    (paddr == IRQ_CLR_OFS) || (paddr == TRAP_ADDR_OFS);

    // Ready answers in the first access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            case (paddr)
                CTRL_OFS:      prdata <= ctrl;
                STATUS_OFS:    prdata <= {30'h0000_0000, status};
                IRQ_EN_OFS:    prdata <= {30'h0000_0000, irq_en};
                TRAP_ADDR_OFS: prdata <= trap_addr;
                default:       prdata <= 32'h0000_0000;  // Clear and unmapped read zero
            endcase
        end
    end

    // Control and enable writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl   <= CTRL_RST;
            irq_en <= IRQ_EN_RST;
        end else if (access && pwrite) begin
            if (paddr == CTRL_OFS) begin
                ctrl <= {31'h0000_0000, pwdata[CTRL_ENABLE_BIT]};
            end
            if (paddr == IRQ_EN_OFS) begin
                irq_en <= pwdata[EVENT_W-1:0];
            end
        end
    end

    // Events and software clear
    assign event_set = {unhandled, trap_fire};
    assign clr_mask  = (access && pwrite && paddr == IRQ_CLR_OFS) ?
                       pwdata[EVENT_W-1:0] : 2'h0;

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= 2'h0;
        end else begin
            status <= (status & ~clr_mask) | event_set;
        end
    end

    // Interrupt level from enabled status, one cycle behind
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & irq_en);
        end
    end

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Helper: immediate trap accepted
    logic take_trap;
    assign take_trap = take && dec_bus.is_trap;

    // A selected true condition raises the request next cycle
    property p_trap_taken;
        trap_fire |=> trap_req && $past(instr_addr) == trap_addr;
    endproperty
    a_trap_taken: assert property (p_trap_taken)
        else $error("trap not raised with its address");

    // Unselected conditions raise nothing
    property p_trap_quiet;
        take_trap && ((cmp_hits(cmp_value, sext16(instr[15:0])) & instr[25:21]) == 5'h00)
            && !trap_req |=> !trap_req;
    endproperty
    a_trap_quiet: assert property (p_trap_quiet)
        else $error("trap raised with no condition met");

    // Trap writes no register and no field 0
    property p_trap_silent;
        take_trap |=> !wb_valid && !cr0_we;
    endproperty
    a_trap_silent: assert property (p_trap_silent)
        else $error("trap produced a writeback");

    // While pending, nothing new is accepted
    property p_trap_hold;
        trap_req && !trap_ack |=> trap_req && !issue_ready;
    endproperty
    a_trap_hold: assert property (p_trap_hold)
        else $error("issue reopened before trap taken");

    // Register xor result and target
    property p_xor_reg;
        take && dec_bus.is_xor |=> wb_valid && wb_data == ($past(src_value) ^ $past(rhs_value))
            && wb_reg == $past(instr[20:16]);
    endproperty
    a_xor_reg: assert property (p_xor_reg)
        else $error("register xor result wrong");

    // Record bit drives field 0 update
    property p_xor_rec;
        take && dec_bus.is_xor |=> cr0_we == $past(instr[0]);
    endproperty
    a_xor_rec: assert property (p_xor_rec)
        else $error("field 0 update does not follow record bit");

    // Field 0 contents match the result
    property p_cr0_value;
        cr0_we |-> cr0_value[1] == (wb_data == 32'h0000_0000)
            && cr0_value[3] == wb_data[31] && cr0_value[0] == $past(so_in);
    endproperty
    a_cr0_value: assert property (p_cr0_value)
        else $error("field 0 value wrong");

    // Low immediate xor keeps the upper half
    property p_xor_low;
        take && dec_bus.is_xor_lo |=> wb_data[31:16] == $past(src_value[31:16])
            && wb_data[15:0] == ($past(src_value[15:0]) ^ $past(instr[15:0])) && !cr0_we;
    endproperty
    a_xor_low: assert property (p_xor_low)
        else $error("low immediate xor wrong");

    // High immediate xor keeps the lower half
    property p_xor_high;
        take && dec_bus.is_xor_hi |=> wb_data[15:0] == $past(src_value[15:0])
            && wb_data[31:16] == ($past(src_value[31:16]) ^ $past(instr[15:0])) && !cr0_we;
    endproperty
    a_xor_high: assert property (p_xor_high)
        else $error("high immediate xor wrong");

    // A trap lands in its sticky status bit, even against a clear
    property p_status_trap;
        trap_fire |=> status[ST_TRAP_BIT];
    endproperty
    a_status_trap: assert property (p_status_trap)
        else $error("trap event not recorded in status");

    // An opcode not served here is recorded for software
    property p_status_unhandled;
        unhandled |=> status[ST_UNHANDLED];
    endproperty
    a_status_unhandled: assert property (p_status_unhandled)
        else $error("unhandled opcode not recorded in status");

    // Main scenarios
    c_trap:     cover property (trap_fire ##[1:20] trap_ack);
    c_xor_rec:  cover property (take && dec_bus.is_xor && dec_bus.rec);
    c_xor_low:  cover property (take && dec_bus.is_xor_lo);
    c_irq:      cover property (!irq ##1 irq);

endmodule

// [dv/exc_unit_model.sv]
/*
 Behavioural exception unit that takes trap requests from the execute slice.
 Assumes trap_req is a level held until the edge where trap_ack is seen.
*/
`timescale 1ns/1ps
module exc_unit_model (
    input  wire logic       pclk,     // Core clock
    input  wire logic       presetn,  // Async reset, active low
    input  wire logic       trap_req, // Trap pending
    input  wire logic [2:0] delay,    // Cycles before taking it
    output logic            trap_ack  // One-cycle take pulse
);
    logic [2:0] wait_cnt; // Cycles waited so far

    // Take a pending trap after the chosen delay, as one pulse only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_ack <= 1'b0;
            wait_cnt <= 3'h0;
        end else if (trap_ack) begin
            trap_ack <= 1'b0; // Request drops on this edge, so no second pulse
            wait_cnt <= 3'h0;
        end else if (trap_req) begin
            if (wait_cnt >= delay) begin
                trap_ack <= 1'b1; // Interrupt taken
            end else begin
                wait_cnt <= wait_cnt + 3'h1; // Slow exception unit
            end
        end
    end
endmodule

// [dv/word_trap_and_xor_unit_test.sv]
/*
 Self-checking bench for the trap and XOR execute slice, with a result model.
 Assumes APB answers within 20 cycles and issue results one cycle after the taken edge.
*/
`timescale 1ns/1ps
module word_trap_and_xor_unit_test;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq; // Bus, irq
    logic        issue_valid, issue_ready, so_in, trap_ack, wb_valid, cr0_we, trap_req;
    logic [7:0]  paddr;                                      // APB address
    logic [31:0] pwdata, prdata, instr, instr_addr, src_value; // Bus and operands
    logic [31:0] cmp_value, rhs_value, wb_data, trap_addr;    // Operands and results
    logic [4:0]  wb_reg, e_reg;                               // Target register
    logic [3:0]  cr0_value, e_cr;                             // Field 0 value
    logic [2:0]  ack_delay;                                   // Partner latency
    int          bad_count, checked, st_model, k;             // Counters, model status
    logic        due_wb, due_cr, due_trap, pend, rerr;        // Model expectations
    logic [31:0] e_addr, last_trap, rd, w;                    // Model values
    logic [31:0] wb_q[$];                                     // Expected writeback data

    word_trap_and_xor_unit word_trap_and_xor_unit_inst (.pclk, .presetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq, .issue_valid,
        .issue_ready, .instr, .instr_addr, .src_value, .cmp_value, .rhs_value, .so_in,
        .trap_ack, .wb_valid, .wb_reg, .wb_data, .cr0_we, .cr0_value, .trap_req,
        .trap_addr);
    exc_unit_model exc_unit_model_inst (.pclk, .presetn, .trap_req, .delay(ack_delay),
        .trap_ack);

    // Free-running core clock, 50 ns
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t bit got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t word got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("Mismatches %0d, comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // One APB transfer, entered just after a rising edge; ends with an idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) cmp_bit(pready, 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0000_0000);
        cmp_word(rd, exp);
        cmp_bit(rerr, err);
    endtask

    // Sample a settled level mid-cycle, then return to a rising edge
    task automatic level_chk(input logic got_sel, input logic exp);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        cmp_bit(got_sel ? irq : issue_ready, exp);
        @(posedge pclk);
    endtask

    // Offer one instruction and hold it until taken; no gap between sends
    task automatic send(input logic [31:0] word, input logic [31:0] s, input logic [31:0] c,
                        input logic [31:0] r);
        int n;
        n = 0;
        issue_valid <= 1'b1;
        instr <= word;
        instr_addr <= $urandom & 32'hFFFF_FFFC;
        src_value <= s;
        cmp_value <= c;
        rhs_value <= r;
        so_in <= 1'($urandom);
        ack_delay <= 3'($urandom);
        do begin
            @(posedge pclk);
            n++;
        end while (issue_ready !== 1'b1 && n < 40);
        if (n >= 40) cmp_bit(issue_ready, 1'b1);
    endtask

    // Reference result of an instruction taken at this edge
    task automatic predict();
        logic [31:0] ext;
        logic [31:0] res;
        logic [4:0]  hit;
        ext = {{16{instr[15]}}, instr[15:0]};
        res = 32'h0000_0000;
        hit = {$signed(cmp_value) < $signed(ext), $signed(cmp_value) > $signed(ext),
               cmp_value == ext, cmp_value < ext, cmp_value > ext};
        case (instr[31:26])
            6'h03: due_trap = |(hit & instr[25:21]);
            6'h1A: {due_wb, res} = {1'b1, src_value ^ {16'h0000, instr[15:0]}};
            6'h1B: {due_wb, res} = {1'b1, src_value ^ {instr[15:0], 16'h0000}};
            6'h1F: begin
                if (instr[10:1] == 10'h13C)
                    {due_wb, due_cr, res} = {1'b1, instr[0], src_value ^ rhs_value};
                else st_model |= 2;
            end
            default: st_model |= 2;
        endcase
        if (due_trap) {st_model[0], e_addr, last_trap} = {1'b1, instr_addr, instr_addr};
        e_reg = instr[20:16];
        if (due_wb) wb_q.push_back(res);
        e_cr = {res[31], !res[31] && res != 0, res == 0, so_in};
    endtask

    // Compare every result cycle with the model, then predict the next
    always @(posedge pclk) begin
        if (presetn) begin
            cmp_bit(wb_valid, due_wb);
            cmp_bit(cr0_we, due_cr);
            if (due_wb) cmp_word(wb_data, wb_q.pop_front());
            if (due_wb) cmp_word(32'(wb_reg), 32'(e_reg));
            if (due_cr) cmp_word(32'(cr0_value), 32'(e_cr));
            if (due_trap) cmp_word(trap_addr, e_addr);
            if (due_trap) pend = 1'b1;
            cmp_bit(trap_req, pend);
            if (pend) cmp_bit(issue_ready, 1'b0);
            if (trap_ack === 1'b1) pend = 1'b0;
            {due_wb, due_cr, due_trap} = 3'b000;
            if (issue_valid === 1'b1 && issue_ready === 1'b1) predict();
        end else begin
            {due_wb, due_cr, due_trap, pend} = 4'b0000;
        end
    end

    // Watchdog, well beyond the expected run
    initial begin
        #1000000;
        bad_count++;
        conclude();
    end

    initial begin
        {presetn, psel, penable, pwrite, issue_valid, so_in} = 6'h00;
        {paddr, ack_delay} = 11'h000;
        {pwdata, instr, instr_addr, src_value, cmp_value, rhs_value} = '0;
        {bad_count, checked, st_model} = 0;
        void'($urandom(88571));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd_chk(8'h00, 32'h0000_0001, 1'b0);
        rd_chk(8'h04, 32'h0000_0000, 1'b0);
        rd_chk(8'h08, 32'h0000_0000, 1'b0);
        rd_chk(8'h0C, 32'h0000_0000, 1'b0);
        rd_chk(8'h20, 32'h0000_0000, 1'b1);
        // Worked examples, back to back
        send({6'h1F, 5'h04, 5'h06, 5'h07, 10'h13C, 1'b0}, 32'h9000_3000, 0, 32'h789A_789B);
        send({6'h1F, 5'h04, 5'h06, 5'h07, 10'h13C, 1'b1}, 32'hB004_3000, 0, 32'h789A_789B);
        send({6'h1A, 5'h04, 5'h06, 16'h5730}, 32'h7B41_92C0, 0, 0);
        send({6'h1B, 5'h04, 5'h06, 16'h0079}, 32'h9000_3000, 0, 0);
        send({6'h03, 5'h04, 5'h04, 16'h0010}, 0, 32'h0000_0010, 0);
        // Each condition bit alone, a hit and a miss against 0xFFFF8000
        for (k = 0; k < 5; k++) begin
            w = {6'h03, 5'(5'h10 >> k), 5'h03, 16'h8000};
            send(w, 0, (k == 0) ? 32'h8000_0000 : (k == 2) ? 32'hFFFF_8000 :
                 (k == 4) ? 32'hFFFF_FFFF : 32'h0000_0000, 0);
            send(w, 0, (k == 2) ? 32'h0000_0000 : 32'hFFFF_8000, 0);
        end
        issue_valid <= 1'b0;
        apb(1'b1, 8'h08, 32'h0000_0001);
        level_chk(1'b1, st_model[0]);
        apb(1'b1, 8'h08, 32'h0000_0000);
        level_chk(1'b1, 1'b0);
        rd_chk(8'h10, last_trap, 1'b0);
        // Random mix, with unhandled opcodes and near-boundary compares
        for (k = 0; k < 300; k++) begin
            w = $urandom;
            case ($urandom % 6)
                0: w[31:26] = 6'h03;
                1: w[31:26] = 6'h1A;
                2: w[31:26] = 6'h1B;
                3: w[31:26] = 6'h11;
                default: {w[31:26], w[10:1]} = {6'h1F, ($urandom % 8) ? 10'h13C : 10'h2A5};
            endcase
            rd = {{16{w[15]}}, w[15:0]};
            send(w, $urandom, ($urandom % 3 == 0) ? rd : ($urandom % 2) ? rd ^ 32'h8000_0000 :
                 $urandom, $urandom);
        end
        issue_valid <= 1'b0;
        apb(1'b1, 8'h08, 32'h0000_0003);
        level_chk(1'b1, st_model != 0);
        rd_chk(8'h04, 32'(st_model), 1'b0);
        apb(1'b1, 8'h0C, 32'h0000_0003);
        st_model = 0;
        rd_chk(8'h04, 32'h0000_0000, 1'b0);
        level_chk(1'b1, 1'b0);
        // Disabled slice refuses a held offer, then takes it once enabled
        apb(1'b1, 8'h00, 32'h0000_0000);
        w = {6'h1A, 5'h01, 5'h02, 16'hFFFF};
        {issue_valid, instr, src_value} <= {1'b1, w, 32'h1234_5678};
        level_chk(1'b0, 1'b0);
        apb(1'b1, 8'h00, 32'h0000_0001);
        send(w, 32'h1234_5678, 0, 0);
        issue_valid <= 1'b0;
        level_chk(1'b0, 1'b1);
        repeat (10) @(posedge pclk);
        conclude();
    end
endmodule
